// >>> hdl/ptacc_pkg.sv
/*
 * Package for the program-space table access block: operation codes,
 * widths, page register layout and the register-port map.
 * Assumes nothing of its surroundings.
 */
package ptacc_pkg;

    localparam int PTACC_PWORD_W = 24;
    localparam int PTACC_DWORD_W = 16;
    localparam int PTACC_EA_W = 16;
    localparam int PTACC_PAGE_W = 8;
    localparam int PTACC_PADDR_W = PTACC_PAGE_W + PTACC_EA_W;

    // Page register layout
    localparam int PTACC_PAGE_CFG_BIT = 7;
    localparam logic [7:0] PTACC_PAGE_RST = 8'h00;

    // Register port map (word offsets on the plain port)
    localparam logic [3:0] PTACC_REG_PAGE = 4'h0;
    localparam logic [3:0] PTACC_REG_STATUS = 4'h1;
    localparam logic [3:0] PTACC_REG_LASTRD = 4'h2;
    localparam int PTACC_STAT_BUSY_BIT = 0;
    localparam int PTACC_STAT_CFG_BIT = 1;
    localparam logic [15:0] PTACC_PHANTOM = 16'h0000;

    typedef enum logic [1:0] {
        PTACC_OP_RD_LOW = 2'b00,
        PTACC_OP_RD_HIGH = 2'b01,
        PTACC_OP_WT_LOW = 2'b10,
        PTACC_OP_WT_HIGH = 2'b11
    } ptacc_op_t;

    typedef enum logic [1:0] {
        PTACC_ST_IDLE = 2'b00,
        PTACC_ST_READ = 2'b01,
        PTACC_ST_DONE = 2'b10
    } ptacc_state_t;

endpackage : ptacc_pkg

// >>> hdl/ptacc_rdmux.sv
/*
 * Read-data shaping: turns a 24-bit program word into the data word that a
 * table read returns, in byte or word mode, low or high space.
 * Assumes the program word is already captured in a register.
 */
`timescale 1ns/1ps

module ptacc_rdmux
    import ptacc_pkg::*;
(
    input wire logic [23:0] pword,
    input wire logic high_space,
    input wire logic byte_mode,
    input wire logic byte_sel,
    output logic [15:0] data
);

    wire [7:0] low_byte_pick;
    wire [7:0] high_byte_pick;
    wire [15:0] low_word;
    wire [15:0] high_word;

    assign low_word = pword[15:0]; // RULE6
    assign low_byte_pick = byte_sel ? pword[15:8] : pword[7:0]; // RULE7
    // Phantom byte reads as zero in either mode
    assign high_word = {PTACC_PHANTOM[15:8], pword[23:16]}; // RULE8 RULE9
    assign high_byte_pick = byte_sel ? PTACC_PHANTOM[7:0] : pword[23:16]; // RULE10

    assign data = high_space
        ? (byte_mode ? {8'h00, high_byte_pick} : high_word)
        : (byte_mode ? {8'h00, low_byte_pick} : low_word); // RULE5

endmodule : ptacc_rdmux

// >>> hdl/ptacc_top.sv
/*
 * Program-space table access: serves table reads and writes from the
 * execution unit against the program array, paged by the page register.
 * Waits on PM_RVALID for as many cycles as the array takes to answer a read,
 * and ignores any request from the execution unit while BUSY is high.
 */
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// RULE1: Low-word table ops reach program word bits directly, no data mapping.
// RULE2: Only high table ops read or write the program word's upper byte.
// RULE3: Program addresses step by two per program word.
// RULE4: Program memory is two 16-bit spaces sharing one address range.
// RULE5: Each table op supports byte or word size, chosen per operation.
// RULE6: Word low read puts program bits 15:0 on data 15:0.
// RULE7: Byte low read picks upper byte if selector one, else lower.
// RULE8: Word high read returns program bits 23:16 as low data byte.
// RULE9: Word high read forces data bits 15:8 to zero.
// RULE10: Byte high read returns selected byte, zero for phantom byte.
// RULE11: Program page accessed always comes from the page register.
// RULE12: Page bit seven zero selects user space, one configuration space.
// RULE13: Byte selector is effective address bit zero.
module ptacc_top
    import ptacc_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    input wire logic OP_VALID,
    input wire logic [1:0] OP_CODE,
    input wire logic OP_BYTE,
    input wire logic [15:0] OP_EA,
    input wire logic [15:0] OP_WDATA,
    output logic BUSY,
    output logic RD_VALID,
    output logic [15:0] RD_DATA,
    output logic PM_REQ,
    output logic PM_WE,
    output logic [22:0] PM_ADDR,
    output logic PM_CFG,
    output logic [23:0] PM_WDATA,
    output logic [2:0] PM_LANES,
    input wire logic PM_RVALID,
    input wire logic [23:0] PM_RDATA
);

    ptacc_state_t state_q;
    ptacc_state_t state_d;
    logic [7:0] page_q;
    logic [15:0] rdata_q;
    logic [15:0] last_rd_q;
    logic [23:0] pword_q;
    logic high_q;
    logic byte_q;
    logic sel_q;
    logic rd_valid_q;
    logic pm_req_q;
    logic pm_we_q;
    logic [22:0] pm_addr_q;
    logic pm_cfg_q;
    logic [23:0] pm_wdata_q;
    logic [2:0] pm_lanes_q;

    wire op_is_high;
    wire op_is_write;
    wire op_take;
    wire byte_sel;
    wire [22:0] word_addr;
    wire [23:0] wr_pdata;
    wire [2:0] wr_lanes;
    wire [15:0] shaped;
    wire page_wr;
    wire [15:0] status_word;
    wire [15:0] reg_mux;

    assign op_is_high = OP_CODE[0];
    assign op_is_write = OP_CODE[1];
    assign op_take = OP_VALID && (state_q == PTACC_ST_IDLE);
    assign byte_sel = OP_EA[0]; // RULE13
    // Bit 0 of the address is the byte selector, so one program word spans
    // two address units and the word index drops it.
    assign word_addr = {page_q, OP_EA[15:1]}; // RULE3 RULE11 RULE1

    ptacc_wrmux u_wrmux (
        .wdata(OP_WDATA),
        .high_space(op_is_high),
        .byte_mode(OP_BYTE),
        .byte_sel(byte_sel),
        .pdata(wr_pdata),
        .lanes(wr_lanes)
    );

    ptacc_rdmux u_rdmux (
        .pword(pword_q),
        .high_space(high_q),
        .byte_mode(byte_q),
        .byte_sel(sel_q),
        .data(shaped)
    );

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PTACC_ST_IDLE: begin
                if (op_take && !op_is_write) begin
                    state_d = PTACC_ST_READ;
                end
            end
            PTACC_ST_READ: begin
                if (PM_RVALID) begin
                    state_d = PTACC_ST_DONE;
                end
            end
            PTACC_ST_DONE: begin
                state_d = PTACC_ST_IDLE;
            end
            default: begin
                state_d = PTACC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_q <= PTACC_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign page_wr = REG_WR && (REG_ADDR == PTACC_REG_PAGE);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            page_q <= PTACC_PAGE_RST;
        end else if (page_wr) begin
            page_q <= REG_WDATA[7:0]; // RULE11
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pm_req_q <= 1'b0;
            pm_we_q <= 1'b0;
            pm_addr_q <= 23'h000000;
            pm_cfg_q <= 1'b0;
            pm_wdata_q <= 24'h000000;
            pm_lanes_q <= 3'h0;
        end else begin
            pm_req_q <= op_take;
            pm_we_q <= op_take && op_is_write;
            if (op_take) begin
                pm_addr_q <= word_addr;
                pm_cfg_q <= page_q[PTACC_PAGE_CFG_BIT]; // RULE12
                pm_wdata_q <= op_is_write ? wr_pdata : 24'h000000;
                pm_lanes_q <= op_is_write ? wr_lanes : 3'h0; // RULE2
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            high_q <= 1'b0;
            byte_q <= 1'b0;
            sel_q <= 1'b0;
        end else if (op_take) begin
            high_q <= op_is_high; // RULE4
            byte_q <= OP_BYTE;
            sel_q <= byte_sel;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pword_q <= 24'h000000;
        end else if (state_q == PTACC_ST_READ && PM_RVALID) begin
            pword_q <= PM_RDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rd_valid_q <= 1'b0;
            last_rd_q <= 16'h0000;
        end else begin
            rd_valid_q <= 1'b0;
            if (state_q == PTACC_ST_DONE) begin
                rd_valid_q <= 1'b1;
                last_rd_q <= shaped; // RULE2 RULE5
            end
        end
    end

    assign status_word = {14'h0000, page_q[PTACC_PAGE_CFG_BIT],
                          (state_q != PTACC_ST_IDLE)};
    assign reg_mux = (REG_ADDR == PTACC_REG_PAGE) ? {8'h00, page_q}
        : (REG_ADDR == PTACC_REG_STATUS) ? status_word
        : (REG_ADDR == PTACC_REG_LASTRD) ? last_rd_q
        : 16'h0000;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata_q <= 16'h0000;
        end else if (REG_RD) begin
            rdata_q <= reg_mux;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign REG_RDATA = rdata_q;
    assign BUSY = (state_q != PTACC_ST_IDLE);
    assign RD_VALID = rd_valid_q;
    assign RD_DATA = last_rd_q;
    assign PM_REQ = pm_req_q;
    assign PM_WE = pm_we_q;
    assign PM_ADDR = pm_addr_q;
    assign PM_CFG = pm_cfg_q;
    assign PM_WDATA = pm_wdata_q;
    assign PM_LANES = pm_lanes_q;

endmodule : ptacc_top

// >>> hdl/ptacc_wrmux.sv
/*
 * Write-data shaping: builds the 24-bit lane data and lane enables that a
 * table write sends to the program array.
 * Assumes the array honours per-byte lane enables.
 */
`timescale 1ns/1ps

module ptacc_wrmux
    import ptacc_pkg::*;
(
    input wire logic [15:0] wdata,
    input wire logic high_space,
    input wire logic byte_mode,
    input wire logic byte_sel,
    output logic [23:0] pdata,
    output logic [2:0] lanes
);

    wire [2:0] low_lanes;
    wire [2:0] high_lanes;

    assign low_lanes = byte_mode ? (byte_sel ? 3'h2 : 3'h1) : 3'h3;
    // Writes to the phantom byte touch nothing
    assign high_lanes = (byte_mode && byte_sel) ? 3'h0 : 3'h4; // RULE2
    assign lanes = high_space ? high_lanes : low_lanes; // RULE4 RULE5
    assign pdata = high_space
        ? {wdata[7:0], 16'h0000}
        : (byte_mode ? {8'h00, wdata[7:0], wdata[7:0]}
                     : {8'h00, wdata});

endmodule : ptacc_wrmux

// >>> testbench/ptacc_checker.sv
/*
 * Checker for the table access block: ties program-array requests and
 * read data to the table operation that caused them.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps

module ptacc_checker
    import ptacc_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic OP_VALID,
    input wire logic [1:0] OP_CODE,
    input wire logic OP_BYTE,
    input wire logic [15:0] OP_EA,
    input wire logic BUSY,
    input wire logic RD_VALID,
    input wire logic [15:0] RD_DATA,
    input wire logic PM_REQ,
    input wire logic [22:0] PM_ADDR,
    input wire logic PM_CFG,
    input wire logic [2:0] PM_LANES,
    input wire logic PM_RVALID,
    input wire logic [23:0] PM_RDATA
);
    logic [7:0] pg_q;
    logic [1:0] op_q;
    logic by_q;
    logic sel_q;
    logic [23:0] pw_q;
    wire take = OP_VALID && !BUSY;
    wire rlo = RD_VALID && op_q == PTACC_OP_RD_LOW;
    wire rhi = RD_VALID && op_q == PTACC_OP_RD_HIGH;
    wire wlo = take && OP_CODE == PTACC_OP_WT_LOW;

    always_ff @(posedge CLK) begin
        if (REG_WR && REG_ADDR == PTACC_REG_PAGE) pg_q <= REG_WDATA[7:0];
        if (RESET) pg_q <= 8'h00;
        if (take) op_q <= OP_CODE;
        if (take) by_q <= OP_BYTE;
        if (take) sel_q <= OP_EA[0];
        if (PM_RVALID) pw_q <= PM_RDATA;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    AST_TAKE_REQ: assert property (take |=> PM_REQ)
        else $error("no array request after a taken op");
    AST_ADDR: assert property (take |=>
        PM_ADDR == {$past(pg_q), $past(OP_EA[15:1])})
        else $error("array address not page and word address");
    AST_CFG: assert property (take |=> PM_CFG == $past(pg_q[7]))
        else $error("space select differs from page bit 7");
    AST_RD_LAT: assert property (BUSY && PM_RVALID |-> ##2 RD_VALID)
        else $error("read result late");
    AST_LO_WORD: assert property (rlo && !by_q |->
        RD_DATA == pw_q[15:0])
        else $error("low word read data wrong");
    AST_LO_BYTE: assert property (rlo && by_q |->
        RD_DATA[7:0] == (sel_q ? pw_q[15:8] : pw_q[7:0]))
        else $error("low byte read data wrong");
    AST_HI_WORD: assert property (rhi && !by_q |->
        RD_DATA == {8'h00, pw_q[23:16]})
        else $error("high word read data wrong");
    AST_HI_BYTE: assert property (rhi && by_q |->
        RD_DATA[7:0] == (sel_q ? 8'h00 : pw_q[23:16]))
        else $error("high byte read data wrong");
    AST_WT_LO: assert property (wlo && !OP_BYTE |=> PM_LANES == 3'b011)
        else $error("low word write lanes wrong");
    AST_WT_BYTE: assert property (wlo && OP_BYTE |=>
        PM_LANES == ($past(OP_EA[0]) ? 3'b010 : 3'b001))
        else $error("low byte write lanes wrong");
    AST_WT_HI: assert property (take && OP_CODE == PTACC_OP_WT_HIGH
        && !OP_BYTE |=> PM_LANES == 3'b100)
        else $error("high word write lanes wrong");
endmodule : ptacc_checker

bind ptacc_top ptacc_checker i_chk (.CLK(CLK), .RESET(RESET),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_BYTE(OP_BYTE),
    .OP_EA(OP_EA), .BUSY(BUSY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
    .PM_REQ(PM_REQ), .PM_ADDR(PM_ADDR), .PM_CFG(PM_CFG),
    .PM_LANES(PM_LANES), .PM_RVALID(PM_RVALID), .PM_RDATA(PM_RDATA));

// >>> testbench/ptacc_pmem.sv
/*
 * Program array model: byte-lane writes, reads answered after a chosen
 * delay. Assumes one read outstanding at a time.
 */
`timescale 1ns/1ps

module ptacc_pmem (
    input wire logic clk,
    input wire logic req,
    input wire logic we,
    input wire logic [22:0] addr,
    input wire logic [23:0] wd,
    input wire logic [2:0] ln,
    input wire logic [3:0] dly,
    output logic rv = 1'b0,
    output logic [23:0] rd = 24'h000000
);
    logic [23:0] mem [32];
    logic [4:0] a_q;
    logic [3:0] cnt = 4'h0;

    initial begin
        for (int k = 0; k < 32; k++) mem[k] = 24'h000000;
    end

    always @(posedge clk) begin
        rv <= 1'b0;
        // Read data lines are not held once the answer is gone
        rd <= ~rd;
        for (int k = 0; k < 3; k++) begin
            if (req && we && ln[k]) mem[addr[4:0]][8*k +: 8] <= wd[8*k +: 8];
        end
        if (req && !we) begin
            a_q <= addr[4:0];
            cnt <= dly + 4'h1;
        end else if (cnt == 4'h1) begin
            rv <= 1'b1;
            rd <= mem[a_q];
            cnt <= 4'h0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule : ptacc_pmem

// >>> testbench/tb_top.sv
/*
 * Bench: random table writes and reads checked against a shadow array.
 * Assumes the checker binds itself and the array model answers reads.
 */
`timescale 1ns/1ps

module tb_top
    import ptacc_pkg::*;
;
    logic CLK, RESET, REG_WR, REG_RD, OP_VALID, OP_BYTE, BUSY, RD_VALID;
    logic PM_REQ, PM_WE, PM_CFG, PM_RVALID;
    logic [3:0] REG_ADDR, dly;
    logic [1:0] OP_CODE;
    logic [2:0] PM_LANES;
    logic [15:0] REG_WDATA, REG_RDATA, OP_EA, OP_WDATA, RD_DATA, v;
    logic [22:0] PM_ADDR;
    logic [23:0] PM_WDATA, PM_RDATA;
    logic [23:0] sh [32];
    integer seed = 32'hfa124c18;
    int miscompares = 0;
    int check_count = 0;

    ptacc_top i_dut (.CLK(CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
        .OP_BYTE(OP_BYTE), .OP_EA(OP_EA), .OP_WDATA(OP_WDATA), .BUSY(BUSY),
        .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .PM_REQ(PM_REQ),
        .PM_WE(PM_WE), .PM_ADDR(PM_ADDR), .PM_CFG(PM_CFG),
        .PM_WDATA(PM_WDATA), .PM_LANES(PM_LANES), .PM_RVALID(PM_RVALID),
        .PM_RDATA(PM_RDATA));
    ptacc_pmem i_pm (.clk(CLK), .req(PM_REQ), .we(PM_WE), .addr(PM_ADDR),
        .wd(PM_WDATA), .ln(PM_LANES), .dly(dly), .rv(PM_RVALID),
        .rd(PM_RDATA));

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    function automatic logic [23:0] upd(logic h, b, s, logic [15:0] d,
        logic [23:0] w);
        if (h && !(b && s)) w[23:16] = d[7:0];
        if (!h && !b) w[15:0] = d;
        if (!h && b && s) w[15:8] = d[7:0];
        if (!h && b && !s) w[7:0] = d[7:0];
        return w;
    endfunction : upd

    function automatic logic [15:0] exp_rd(logic h, b, s, logic [23:0] w);
        if (h) return (b && s) ? 16'h0000 : {8'h00, w[23:16]};
        if (!b) return w[15:0];
        return {8'h00, s ? w[15:8] : w[7:0]};
    endfunction : exp_rd

    task automatic chk(input string n, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask : rreg

    task automatic op(input logic [1:0] c, input logic b,
        input logic [15:0] ea, d);
        @(posedge CLK);
        OP_VALID <= 1'b1;
        OP_CODE <= c;
        OP_BYTE <= b;
        OP_EA <= ea;
        OP_WDATA <= d;
    endtask : op

    task automatic rd_op(input logic h, b, s, input logic [4:0] a);
        int i;
        dly <= 4'($random(seed)) & 4'h3;
        op({1'b0, h}, b, {10'h000, a, s}, 16'h0000);
        // Held one more edge while busy: must be ignored
        if (seed[0]) op({1'b0, h}, b, {10'h000, a, s}, 16'hffff);
        @(posedge CLK);
        OP_VALID <= 1'b0;
        i = 0;
        while (RD_VALID !== 1'b1 && i < 16) begin
            @(posedge CLK);
            #1 i++;
        end
        if (i == 16) begin
            miscompares++;
            close_out;
        end
    endtask : rd_op

    initial begin
        logic [4:0] a;
        logic h, b, s;
        logic [15:0] d;
        {REG_WR, REG_RD, OP_VALID, OP_BYTE, RESET} = 5'h01;
        {REG_ADDR, REG_WDATA, OP_CODE, OP_EA, OP_WDATA, dly} = 58'h0;
        for (int n = 0; n < 32; n++) sh[n] = 24'h000000;
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        rreg(PTACC_REG_PAGE, v);
        chk("page", v, 16'h0000);
        rreg(4'hf, v);
        chk("unmapped", v, 16'h0000);
        op(PTACC_OP_WT_LOW, 1'b0, 16'h0000, 16'hffff);
        op(PTACC_OP_WT_HIGH, 1'b0, 16'h0000, 16'hffff);
        sh[0] = 24'hffffff;
        rd_op(1'b1, 1'b1, 1'b1, 5'h00);
        chk("phantom", RD_DATA, 16'h0000);
        for (int n = 0; n < 240; n++) begin
            if (n % 16 == 0) begin
                d = {8'h00, 8'($random(seed))};
                @(posedge CLK);
                REG_ADDR <= PTACC_REG_PAGE;
                REG_WDATA <= d;
                REG_WR <= 1'b1;
                @(posedge CLK);
                REG_WR <= 1'b0;
                rreg(PTACC_REG_STATUS, v);
                chk("cfg", v, {14'h0, d[7], 1'b0});
            end
            for (int k = 0; k < 2; k++) begin
                {a, h, b, s} = 8'($random(seed));
                d = 16'($random(seed));
                op({1'b1, h}, b, {10'h000, a, s}, d);
                sh[a] = upd(h, b, s, d, sh[a]);
            end
            {h, b, s} = 3'($random(seed));
            rd_op(h, b, s, a);
            v = exp_rd(h, b, s, sh[a]);
            chk("rd", b ? {8'h00, RD_DATA[7:0]} : RD_DATA, v);
            rreg(PTACC_REG_LASTRD, d);
            chk("lastrd", d, v);
        end
        close_out;
    end
endmodule : tb_top
